// ===== pkg/ddc_defines.svh
// Constants for the dual DAC serial command port
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
`define DDC_FRAME_BITS 24
`define DDC_CNT_W 5
`define DDC_CMD_HI 23
`define DDC_CMD_LO 20
`define DDC_ADDR_B 19
`define DDC_ADDR_A 16
`define DDC_DATA_HI 15
`define DDC_DATA_W 16
`define DDC_PD_A_LO 0
`define DDC_PD_B_LO 6
`define DDC_MASK_A 0
`define DDC_MASK_B 1
`define DDC_REF_OFF_BIT 0
`define DDC_CHAIN_BIT 0
`define DDC_RDBK_BIT 0
`define DDC_REF_RST 1'b1
`define DDC_CLK_NS 20
`define DDC_GAP_NS 20
`define DDC_GAP_CYC ((`DDC_GAP_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_SCLK_HALF 4
`define DDC_LOAD_CYC 8
`endif

// ===== pkg/ddc_pkg.sv
// Types shared by both ends of the serial command port
package ddc_pkg;
  typedef enum logic [3:0] {
    DDC_NOP = 4'h0,
    DDC_WR_IN = 4'h1,
    DDC_UPD = 4'h2,
    DDC_WR_UPD = 4'h3,
    DDC_PWR = 4'h4,
    DDC_MASK = 4'h5,
    DDC_SW_RST = 4'h6,
    DDC_REF = 4'h7,
    DDC_CHAIN = 4'h8,
    DDC_RDBK = 4'h9,
    DDC_CHAIN_NOP = 4'hf
  } ddc_cmd_t;

  typedef enum logic [2:0] {
    DDC_H_IDLE = 3'b000,
    DDC_H_SETUP = 3'b001,
    DDC_H_HIGH = 3'b010,
    DDC_H_LOW = 3'b011,
    DDC_H_END = 3'b100,
    DDC_H_GAP = 3'b101,
    DDC_H_LOAD = 3'b110
  } ddc_hstate_t;
endpackage

// ===== pkg/ddc_link_if.sv
// Serial link between the host controller and the DAC command port
`timescale 1ns/1ps
interface ddc_link_if;
  logic sclk;
  logic frame_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe_n;
  logic load_outputs_n;

  modport dev (
    input sclk,
    input frame_n,
    input serial_data_in,
    input load_outputs_n,
    output serial_data_out,
    output serial_data_out_oe_n
  );

  modport host (
    output sclk,
    output frame_n,
    output serial_data_in,
    output load_outputs_n,
    input serial_data_out,
    input serial_data_out_oe_n
  );
endinterface

// ===== rtl/ddc_device.sv
// DAC end of the serial command port: frame capture and command decode
// What this block does
// - Frames are 24 bits, MSB first.
// - First four bits form the command field.
// - Address bits: B, zero, zero, A select.
// - Last 16 bits hold left-justified code.
// - Sample on falling edges; act on frame end.
// - Nop, write input, update, write-and-update.
// - Power, mask, reset, reference, chain, readback.
// - Codes above readback reserved; all-ones is nop.
// - Host frames writes and sends 24 bits.
// - Short frames still execute.
// - Host keeps frame high 20 ns between.
// - Load strobe low copies inputs to DACs.
// - Reference on at reset until commanded off.
// - Reset puts DAC registers at known code.
// - Codes are straight binary output levels.
// - Gain strap selects gain one or two.
// - Load low makes DAC register transparent.
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_device #(
  parameter int RES = 16,
  parameter logic [RES-1:0] RESET_CODE = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  ddc_link_if.dev link,
  input wire logic gain_strap,
  output logic [1:0][RES-1:0] dac_code,
  output logic [1:0][RES-1:0] input_code,
  output logic [1:0][1:0] power_mode,
  output logic [1:0] load_mask,
  output logic gain_x2,
  output logic ref_enabled,
  output logic chain_enable,
  output logic readback_enable,
  output logic frame_done
);
  // Frame length at the counter's own width
  localparam logic [`DDC_CNT_W-1:0] FRAME_BITS = `DDC_CNT_W'(`DDC_FRAME_BITS);

  // Two-flop synchronisers for every pin from the far end
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sclk_prev_q;
  logic frame_prev_q;
  always_ff @(posedge clk) begin
    meta_q <= {gain_strap, link.load_outputs_n, link.serial_data_in,
               link.frame_n, link.sclk};
    sync_q <= meta_q;
    sclk_prev_q <= sync_q[0];
    frame_prev_q <= sync_q[1];
  end

  wire sclk_s = sync_q[0];
  wire frame_n_s = sync_q[1];
  wire sdi_s = sync_q[2];
  wire load_outputs_n_n_s = sync_q[3];
  wire gain_s = sync_q[4];

  // Edge detection on the synchronised link
  wire sclk_fall = sclk_prev_q & ~sclk_s;
  wire frame_fall = frame_prev_q & ~frame_n_s;
  wire frame_rise = ~frame_prev_q & frame_n_s;

  // Shift register and bit counter
  logic [`DDC_FRAME_BITS-1:0] shreg_q;
  logic [`DDC_CNT_W-1:0] cnt_q;
  logic in_frame_q;
  wire take_bit = sclk_fall & ~frame_n_s & in_frame_q
                  & (cnt_q < FRAME_BITS);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shreg_q <= '0;
      cnt_q <= '0;
      in_frame_q <= 1'b0;
    end else if (frame_fall) begin
      cnt_q <= '0;
      in_frame_q <= 1'b1;
    end else if (take_bit) begin
      shreg_q <= {shreg_q[`DDC_FRAME_BITS-2:0], sdi_s};
      cnt_q <= cnt_q + 1'b1;
    end else if (frame_rise) begin
      in_frame_q <= 1'b0;
    end
  end

  // Frame decode, acted on at the frame's rising edge
  wire exec = frame_rise & in_frame_q;
  wire [3:0] cmd = shreg_q[`DDC_CMD_HI:`DDC_CMD_LO];
  wire [1:0] sel = {shreg_q[`DDC_ADDR_B], shreg_q[`DDC_ADDR_A]};
  wire [`DDC_DATA_W-1:0] data = shreg_q[`DDC_DATA_HI:0];
  wire [RES-1:0] code = data[`DDC_DATA_W-1 -: RES];

  // Command strobes; reserved codes and both nops match none of them
  wire is_wr_in = exec & (cmd == ddc_pkg::DDC_WR_IN);
  wire is_upd = exec & (cmd == ddc_pkg::DDC_UPD);
  wire is_wr_upd = exec & (cmd == ddc_pkg::DDC_WR_UPD);
  wire is_pwr = exec & (cmd == ddc_pkg::DDC_PWR);
  wire is_mask = exec & (cmd == ddc_pkg::DDC_MASK);
  wire is_ref = exec & (cmd == ddc_pkg::DDC_REF);
  wire is_chain = exec & (cmd == ddc_pkg::DDC_CHAIN);
  wire is_rdbk = exec & (cmd == ddc_pkg::DDC_RDBK);
  wire soft_rst = exec & (cmd == ddc_pkg::DDC_SW_RST);
  wire clr = ~rst_b | soft_rst;

  // Per-channel input register, DAC register, power mode and mask
  wire [1:0][RES-1:0] inp_all;
  wire [1:0][RES-1:0] dac_all;
  wire [1:0][1:0] pd_all;
  wire [1:0] mask_all;
  localparam int PD_LO [2] = '{`DDC_PD_A_LO, `DDC_PD_B_LO};
  localparam int MASK_BIT [2] = '{`DDC_MASK_A, `DDC_MASK_B};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      // Each channel owns its registers, so no variable has two writers
      logic [RES-1:0] inp_q;
      logic [RES-1:0] dac_q;
      logic [1:0] pd_q;
      logic mask_q;
      // Load strobe passes only to unmasked channels while frame is high
      wire load_outputs_n_live = ~load_outputs_n_n_s & ~mask_q & frame_n_s;
      wire wr_in = (is_wr_in | is_wr_upd) & sel[ch];
      wire wr_dac = (is_wr_upd | (is_wr_in & load_outputs_n_live)) & sel[ch];
      always_ff @(posedge clk) begin
        if (clr) begin
          inp_q <= RESET_CODE;
          dac_q <= RESET_CODE;
          pd_q <= '0;
          mask_q <= 1'b0;
        end else begin
          if (wr_in) begin
            inp_q <= code;
          end
          if (wr_dac) begin
            dac_q <= code;
          end else if ((is_upd & sel[ch]) | load_outputs_n_live) begin
            dac_q <= inp_q;
          end
          if (is_pwr) begin
            pd_q <= data[PD_LO[ch] +: 2];
          end
          if (is_mask) begin
            mask_q <= data[MASK_BIT[ch]];
          end
        end
      end
      // Gather the channel's registers into the shared output words
      assign inp_all[ch] = inp_q;
      assign dac_all[ch] = dac_q;
      assign pd_all[ch] = pd_q;
      assign mask_all[ch] = mask_q;
    end
  endgenerate

  // Mode bits shared by both channels
  logic ref_q;
  logic chain_q;
  logic rdbk_q;
  logic gain_q;
  logic done_q;
  always_ff @(posedge clk) begin
    if (clr) begin
      ref_q <= `DDC_REF_RST;
      chain_q <= 1'b0;
      rdbk_q <= 1'b0;
    end else begin
      if (is_ref) begin
        ref_q <= ~data[`DDC_REF_OFF_BIT];
      end
      if (is_chain) begin
        chain_q <= data[`DDC_CHAIN_BIT];
      end
      if (is_rdbk) begin
        rdbk_q <= data[`DDC_RDBK_BIT];
      end
    end
  end

  // Gain strap and frame-done pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gain_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      gain_q <= gain_s;
      done_q <= exec;
    end
  end

  // Serial data out is never driven, even with chain or readback enabled
  assign link.serial_data_out = 1'b0;
  assign link.serial_data_out_oe_n = 1'b1;

  // Registered state straight to the outputs
  assign dac_code = dac_all;
  assign input_code = inp_all;
  assign power_mode = pd_all;
  assign load_mask = mask_all;
  assign gain_x2 = gain_q;
  assign ref_enabled = ref_q;
  assign chain_enable = chain_q;
  assign readback_enable = rdbk_q;
  assign frame_done = done_q;
endmodule

// ===== rtl/ddc_host.sv
// Host end of the serial command port: frames 24-bit writes and load strobes
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_host #(
  parameter int SCLK_HALF = `DDC_SCLK_HALF,
  parameter int LOAD_CYC = `DDC_LOAD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  ddc_link_if.host link,
  input wire logic start,
  input wire logic [3:0] command_field,
  input wire logic [3:0] addr,
  input wire logic [15:0] data,
  input wire logic load_req,
  output logic busy,
  output logic done
);
  localparam int GAP = (`DDC_GAP_CYC > SCLK_HALF) ? `DDC_GAP_CYC : SCLK_HALF;
  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
  localparam logic [7:0] GAP_M1 = 8'(GAP - 1);
  localparam logic [7:0] LOAD_M1 = 8'(LOAD_CYC - 1);

  ddc_pkg::ddc_hstate_t st_q;
  logic [`DDC_FRAME_BITS-1:0] sh_q;
  logic [`DDC_CNT_W-1:0] bits_q;
  logic [7:0] tmr_q;
  logic sclk_q;
  logic frame_n_q;
  logic load_outputs_n_n_q;
  logic done_q;

  wire tmr_end = (tmr_q == 8'h00);
  wire last_bit = (bits_q == `DDC_CNT_W'(`DDC_FRAME_BITS - 1));

  // Frame sequencer: sclk idles high, data changes while sclk is high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= ddc_pkg::DDC_H_IDLE;
      sh_q <= '0;
      bits_q <= '0;
      tmr_q <= 8'h00;
      sclk_q <= 1'b1;
      frame_n_q <= 1'b1;
      load_outputs_n_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!tmr_end) begin
        tmr_q <= tmr_q - 8'h01;
      end
      unique case (st_q)
        ddc_pkg::DDC_H_IDLE: begin
          if (start) begin
            sh_q <= {command_field, addr, data};
            frame_n_q <= 1'b0;
            bits_q <= '0;
            tmr_q <= HALF_M1;
            st_q <= ddc_pkg::DDC_H_SETUP;
          end else if (load_req) begin
            load_outputs_n_n_q <= 1'b0;
            tmr_q <= LOAD_M1;
            st_q <= ddc_pkg::DDC_H_LOAD;
          end
        end
        ddc_pkg::DDC_H_SETUP, ddc_pkg::DDC_H_HIGH: begin
          if (tmr_end) begin
            sclk_q <= 1'b0;
            tmr_q <= HALF_M1;
            st_q <= ddc_pkg::DDC_H_LOW;
          end
        end
        ddc_pkg::DDC_H_LOW: begin
          if (tmr_end) begin
            sclk_q <= 1'b1;
            tmr_q <= HALF_M1;
            if (last_bit) begin
              st_q <= ddc_pkg::DDC_H_END;
            end else begin
              sh_q <= {sh_q[`DDC_FRAME_BITS-2:0], 1'b0};
              bits_q <= bits_q + 1'b1;
              st_q <= ddc_pkg::DDC_H_HIGH;
            end
          end
        end
        ddc_pkg::DDC_H_END: begin
          if (tmr_end) begin
            frame_n_q <= 1'b1;
            tmr_q <= GAP_M1;
            st_q <= ddc_pkg::DDC_H_GAP;
          end
        end
        ddc_pkg::DDC_H_GAP: begin
          if (tmr_end) begin
            done_q <= 1'b1;
            st_q <= ddc_pkg::DDC_H_IDLE;
          end
        end
        ddc_pkg::DDC_H_LOAD: begin
          if (tmr_end) begin
            load_outputs_n_n_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= ddc_pkg::DDC_H_IDLE;
          end
        end
        default: begin
          st_q <= ddc_pkg::DDC_H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.frame_n = frame_n_q;
  assign link.serial_data_in = sh_q[`DDC_FRAME_BITS-1];
  assign link.load_outputs_n = load_outputs_n_n_q;
  assign busy = (st_q != ddc_pkg::DDC_H_IDLE);
  assign done = done_q;
endmodule

// ===== verification/ddc_link_assertions.sv
// Protocol checks on the serial link between host and device ends
`timescale 1ns/1ps
module ddc_link_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  input wire logic load_outputs_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] bits_q;
  // Counts serial clock falls inside one frame
  always_ff @(posedge clk) begin
    if (!rst_b || frame_n) begin
      bits_q <= 5'h0;
    end else if ($fell(sclk)) begin
      bits_q <= bits_q + 5'h1;
    end
  end
  // Frame opening: select falls, clock still idle high
  sequence s_open;
    $fell(frame_n);
  endsequence
  sequence s_idle4;
    sclk [*4];
  endsequence
  a_out_released: assert property (
    serial_data_out_oe_n && !serial_data_out) else $error("data out driven");
  a_open_idle: assert property (
    s_open |-> s_idle4) else $error("clock moved at frame open");
  a_half_period: assert property (
    $changed(sclk) |=> $stable(sclk) [*3]) else $error("clock half too short");
  a_data_hold: assert property (
    $fell(sclk) |-> $stable(serial_data_in)) else $error("data moved at fall");
  a_frame_count: assert property (
    $rose(frame_n) |-> bits_q == 5'h18) else $error("frame not 24 bits");
  a_close_idle: assert property (
    $rose(frame_n) |-> sclk) else $error("frame closed with clock low");
  a_frame_gap: assert property (
    $rose(frame_n) |=> frame_n) else $error("select high too briefly");
  a_load_outside: assert property (
    !load_outputs_n |-> frame_n) else $error("load strobe inside frame");
endmodule

// ===== verification/test_dual_dac_serial_command_port.sv
// Self-checking bench for the dual DAC serial command port
`timescale 1ns/1ps
module test_dual_dac_serial_command_port;
  typedef struct packed {
    logic ld;
    logic [23:0] w;
    logic [31:0] dac;
    logic [31:0] inp;
    logic [8:0] cfg;
  } ddc_row_t;
  logic clk, rst_b, gain_strap, start, load_req, busy, done, done2;
  logic [3:0] command_field, addr;
  logic [15:0] data;
  logic [1:0][15:0] dac_code, input_code, dac2;
  logic [1:0][1:0] power_mode;
  logic [1:0] load_mask;
  logic gain_x2, ref_enabled, chain_enable, readback_enable;
  int fails = 0;
  int check_count = 0;
  // Frame word or load strobe, then expected DAC, input and mode state
  ddc_row_t rows [0:17] = '{
    '{1'h0, 24'h311234, 32'h00001234, 32'h00001234, 9'h004},
    '{1'h0, 24'h18abcd, 32'h00001234, 32'habcd1234, 9'h004},
    '{1'h0, 24'h280000, 32'habcd1234, 32'habcd1234, 9'h004},
    '{1'h0, 24'h39ffff, 32'hffffffff, 32'hffffffff, 9'h004},
    '{1'h0, 24'h105555, 32'hffffffff, 32'hffffffff, 9'h004},
    '{1'h0, 24'h090000, 32'hffffffff, 32'hffffffff, 9'h004},
    '{1'h0, 24'ha90000, 32'hffffffff, 32'hffffffff, 9'h004},
    '{1'h0, 24'hf90000, 32'hffffffff, 32'hffffffff, 9'h004},
    '{1'h0, 24'h4000fd, 32'hffffffff, 32'hffffffff, 9'h1a4},
    '{1'h0, 24'h500002, 32'hffffffff, 32'hffffffff, 9'h1b4},
    '{1'h0, 24'h700001, 32'hffffffff, 32'hffffffff, 9'h1b0},
    '{1'h0, 24'h800001, 32'hffffffff, 32'hffffffff, 9'h1b2},
    '{1'h0, 24'h900001, 32'hffffffff, 32'hffffffff, 9'h1b3},
    '{1'h0, 24'h191111, 32'hffffffff, 32'h11111111, 9'h1b3},
    '{1'h1, 24'h000000, 32'hffff1111, 32'h11111111, 9'h1b3},
    '{1'h0, 24'h600000, 32'h00000000, 32'h00000000, 9'h004},
    '{1'h0, 24'h112222, 32'h00000000, 32'h00002222, 9'h004},
    '{1'h1, 24'h000000, 32'h00002222, 32'h00002222, 9'h004}};
  ddc_link_if link();
  ddc_link_if link2();
  ddc_host ddc_host_inst (.clk(clk), .rst_b(rst_b), .link(link.host),
    .start(start), .command_field(command_field), .addr(addr), .data(data),
    .load_req(load_req), .busy(busy), .done(done));
  ddc_device ddc_device_inst (.clk(clk), .rst_b(rst_b), .link(link.dev),
    .gain_strap(gain_strap), .dac_code(dac_code), .input_code(input_code),
    .power_mode(power_mode), .load_mask(load_mask), .gain_x2(gain_x2),
    .ref_enabled(ref_enabled), .chain_enable(chain_enable),
    .readback_enable(readback_enable), .frame_done());
  // Second device fed by the bench for malformed frames
  ddc_device ddc_device_inst2 (.clk(clk), .rst_b(rst_b), .link(link2.dev),
    .gain_strap(1'b0), .dac_code(dac2), .input_code(), .power_mode(),
    .load_mask(), .gain_x2(), .ref_enabled(), .chain_enable(),
    .readback_enable(), .frame_done(done2));
  ddc_link_assertions ddc_link_assertions_inst (.clk(clk), .rst_b(rst_b),
    .sclk(link.sclk), .frame_n(link.frame_n),
    .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out),
    .serial_data_out_oe_n(link.serial_data_out_oe_n),
    .load_outputs_n(link.load_outputs_n));
  // Clock at 50 MHz
  always #10 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One frame or one load strobe through the host end
  task automatic op(input logic ld, input logic [23:0] w);
    int n = 0;
    @(posedge clk);
    load_req <= ld;
    start <= !ld;
    command_field <= w[23:20];
    addr <= w[19:16];
    data <= w[15:0];
    @(posedge clk);
    start <= 1'b0;
    load_req <= 1'b0;
    @(negedge clk);
    chk("busy", 32'(busy), 32'h1);
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) fails++;
  endtask
  // Raw frame of nb bits from the top of w on the second link
  task automatic raw(input int nb, input logic [25:0] w);
    @(posedge clk);
    link2.frame_n <= 1'b0;
    for (int i = 25; i > 25 - nb; i--) begin
      link2.serial_data_in <= w[i];
      repeat (4) @(posedge clk);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge clk);
      link2.sclk <= 1'b1;
    end
    repeat (4) @(posedge clk);
    link2.frame_n <= 1'b1;
    link2.serial_data_in <= ~w[26-nb];
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end
  // Main sequence
  initial begin
    logic seen;
    clk = 1'b0;
    rst_b = 1'b0;
    gain_strap = 1'b0;
    start = 1'b0;
    load_req = 1'b0;
    command_field = 4'h0;
    addr = 4'h0;
    data = 16'h0;
    link2.sclk = 1'b1;
    link2.frame_n = 1'b1;
    link2.serial_data_in = 1'b0;
    link2.load_outputs_n = 1'b1;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge clk);
    chk("dac", dac_code, 32'h0);
    chk("cfg", 32'({power_mode, load_mask, ref_enabled}), 32'h1);
    chk("oe", 32'(link.serial_data_out_oe_n), 32'h1);
    @(posedge clk);
    gain_strap <= 1'b1;
    repeat (5) @(negedge clk);
    chk("gain", 32'(gain_x2), 32'h1);
    @(posedge clk);
    gain_strap <= 1'b0;
    repeat (5) @(negedge clk);
    chk("gain", 32'(gain_x2), 32'h0);
    for (int i = 0; i < 18; i++) begin
      op(rows[i].ld, rows[i].w);
      repeat (4) @(negedge clk);
      chk("dac", dac_code, rows[i].dac);
      chk("inp", input_code, rows[i].inp);
      chk("cfg", 32'({power_mode, load_mask, ref_enabled, chain_enable,
        readback_enable}), 32'(rows[i].cfg));
    end
    raw(26, {24'h314321, 2'b11});
    repeat (8) @(negedge clk);
    chk("dac2", dac2, 32'h00004321);
    raw(20, {24'h39ffff, 2'b00});
    seen = 1'b0;
    repeat (10) begin
      @(negedge clk);
      if (done2 === 1'b1) seen = 1'b1;
    end
    chk("short", 32'(seen), 32'h1);
    // Write to input B with the load strobe held low on the second link
    @(posedge clk);
    link2.load_outputs_n <= 1'b0;
    raw(24, {24'h185a5a, 2'b00});
    repeat (8) @(negedge clk);
    chk("ldac2", 32'(dac2[1]), 32'h5a5a);
    // Hardware reset in mid-run returns both devices to the reset code
    @(posedge clk);
    link2.load_outputs_n <= 1'b1;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("rst", dac_code, 32'h0);
    chk("rst2", dac2, 32'h0);
    end_of_test;
  end
endmodule
